/* logic/svp_cfg.svh */
// Register map, reset values and timing counts of the space vector PWM
`ifndef SVP_CFG_SVH
`define SVP_CFG_SVH

// Byte offsets of the APB registers
`define SVP_OFF_CTRL  8'h00
`define SVP_OFF_CARR  8'h04
`define SVP_OFF_SCALE 8'h08
`define SVP_OFF_DEAD  8'h0c
`define SVP_OFF_STAT  8'h10

// Control field positions
`define SVP_CTRL_ALIGN 0
`define SVP_CTRL_TWOLEG 1
`define SVP_CTRL_RUN 2

// Reset values
`define SVP_RST_CTRL  3'h0
`define SVP_RST_CARR  16'h1387
`define SVP_RST_SCALE 15'h0000
`define SVP_RST_DEAD  16'h0064

// Calculation latency in clocks, typical count and an upper bound
`define SVP_CALC_TYP 6'h0b
`define SVP_CALC_MAX 6'h23

// Arithmetic constants
`define SVP_LIM      36'sh006000000
`define SVP_LIM_HALF 36'sh003000000
`define SVP_SQ3H     17'sh0ddb4
`define SVP_THIRD    16'sh5555
`define SVP_MID      18'sh08000
`define SVP_DIV_ITER 5'h10
`define SVP_UNITY    17'h10000

`endif

/* logic/svp_pkg.sv */
// Types shared by the space vector PWM generator
package svp_pkg;

	// Alpha/beta modulation command
	typedef struct packed {
		logic signed [15:0] alpha;
		logic signed [15:0] beta;
	} svp_cmd_t;

	// Six gate drive outputs
	typedef struct packed {
		logic gate_u_high;
		logic gate_u_low;
		logic gate_v_high;
		logic gate_v_low;
		logic gate_w_high;
		logic gate_w_low;
	} svp_gate_t;

	typedef logic signed [35:0] svp_ph_t;
	typedef logic [16:0]        svp_time_t;

	// Vector time calculation sequence
	typedef enum logic [2:0] {
		S_IDLE, S_MUL, S_PHS, S_SPR, S_DIV, S_SCL, S_CTR, S_DUT
	} svp_calc_state_t;

endpackage : svp_pkg

/* logic/svp_space_vector_pwm.sv */
// Space vector PWM generator with APB registers and deadtime
`timescale 1ns/1ps
`include "svp_cfg.svh"

module svp_space_vector_pwm (
	// Clock, reset, clock enable
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                ce,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Modulation command from the control loop
	input  wire svp_pkg::svp_cmd_t   cmd,
	input  wire logic                vector_calc_trigger,
	// Cycle marker and leg timings
	output logic                     cycle_boundary_n,
	output svp_pkg::svp_time_t       leg_u_timing,
	output svp_pkg::svp_time_t       leg_v_timing,
	output svp_pkg::svp_time_t       leg_w_timing,
	// Gate drive
	output svp_pkg::svp_gate_t       gates
);
	import svp_pkg::*;

	// Software registers
	logic            align_q;
	logic            twoleg_q;
	logic            run_q;
	logic [15:0]     cval_q;
	logic [14:0]     scl_q;
	logic [15:0]     dt_q;
	logic [31:0]     prdata_q;
	// Calculation state
	svp_calc_state_t st_q;
	svp_cmd_t        cmd_q;
	logic            trig_q;
	logic            tl_calc_q;
	svp_ph_t         pa_q;
	svp_ph_t         pb_q;
	svp_ph_t         ph_q [3];
	logic            ovm_q;
	logic [36:0]     rem_q;
	logic [35:0]     dv_q;
	logic [16:0]     k_q;
	logic [4:0]      bit_q;
	logic [5:0]      cyc_q;
	logic [2:0]      sec_q;
	// Shadow and active copies
	svp_time_t       t_sh_q [3];
	logic            tl_sh_q;
	svp_time_t       t_act_q [3];
	logic [15:0]     dt_act_q;
	logic            tl_act_q;
	// Carrier and outputs
	logic [15:0]     cnt_q;
	logic            up_q;
	logic            bnd_n_q;
	logic [2:0]      hi_q;
	logic [2:0]      lo_q;
	// Register decode, shared by read and write paths
	function automatic logic svp_hit(input logic [7:0] a,
		input logic [7:0] o);
		svp_hit = (a == o);
	endfunction : svp_hit
	// Sector from the order of the three leg references
	function automatic logic [2:0] svp_sector(input logic [2:0] ord);
		case (ord)
			3'b011:  svp_sector = 3'h1;
			3'b010:  svp_sector = 3'h2;
			3'b110:  svp_sector = 3'h3;
			3'b100:  svp_sector = 3'h4;
			3'b101:  svp_sector = 3'h5;
			3'b001:  svp_sector = 3'h6;
			default: svp_sector = 3'h0;
		endcase
	endfunction : svp_sector
	// APB decode; wait states only while the clock enable is low
	wire        busy    = (st_q != S_IDLE);
	wire        a_ctrl  = svp_hit(paddr, `SVP_OFF_CTRL);
	wire        a_carr  = svp_hit(paddr, `SVP_OFF_CARR);
	wire        a_scale = svp_hit(paddr, `SVP_OFF_SCALE);
	wire        a_dead  = svp_hit(paddr, `SVP_OFF_DEAD);
	wire        a_stat  = svp_hit(paddr, `SVP_OFF_STAT);
	wire        mapped  = a_ctrl | a_carr | a_scale | a_dead | a_stat;
	wire        wr_en   = psel & penable & pwrite & mapped & ce;
	wire        setup   = psel & ~penable;
	wire [31:0] stat_w  = {24'h0, up_q, busy, ovm_q, 2'h0, sec_q};
	wire [31:0] rdata_w = a_ctrl  ? {29'h0, run_q, twoleg_q, align_q} :
		a_carr  ? {16'h0, cval_q} :
		a_scale ? {17'h0, scl_q} :
		a_dead  ? {16'h0, dt_q} :
		a_stat  ? stat_w : 32'h0;
	assign pready  = ce;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_q;
	// Register writes; read data latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{run_q, twoleg_q, align_q} <= `SVP_RST_CTRL;
			cval_q   <= `SVP_RST_CARR;
			scl_q    <= `SVP_RST_SCALE;
			dt_q     <= `SVP_RST_DEAD;
			prdata_q <= 32'h0;
		end else if (ce) begin
			if (setup)
				prdata_q <= rdata_w;
			if (wr_en && a_ctrl) begin
				align_q  <= pwdata[`SVP_CTRL_ALIGN];
				twoleg_q <= pwdata[`SVP_CTRL_TWOLEG];
				run_q    <= pwdata[`SVP_CTRL_RUN];
			end
			if (wr_en && a_carr)
				cval_q <= pwdata[15:0];
			if (wr_en && a_scale)
				scl_q <= pwdata[14:0];
			if (wr_en && a_dead)
				dt_q <= pwdata[15:0];
		end
	end
	// Leg references, spread and sector
	wire signed [52:0] sqp = pb_q * `SVP_SQ3H;
	wire svp_ph_t sq   = $signed(sqp[51:16]);
	wire svp_ph_t hlf  = pa_q >>> 1;
	wire svp_ph_t mx01 = (ph_q[0] > ph_q[1]) ? ph_q[0] : ph_q[1];
	wire svp_ph_t mn01 = (ph_q[0] < ph_q[1]) ? ph_q[0] : ph_q[1];
	wire svp_ph_t mx   = (mx01 > ph_q[2]) ? mx01 : ph_q[2];
	wire svp_ph_t mn   = (mn01 < ph_q[2]) ? mn01 : ph_q[2];
	wire svp_ph_t spr  = mx - mn;
	wire          ovm_w = spr > `SVP_LIM;
	wire svp_ph_t off3  = (mx + mn) >>> 1;
	wire svp_ph_t off2  = mn + `SVP_LIM_HALF;
	wire svp_ph_t off   = tl_calc_q ? off2 : off3;
	wire [2:0]    ord   = {ph_q[2] >= ph_q[0], ph_q[1] >= ph_q[2],
		ph_q[0] >= ph_q[1]};
	wire [36:0]   rem_s = {rem_q[35:0], 1'b0};
	wire          q_bit = rem_s >= {1'b0, dv_q};
	wire [16:0]   cp1   = {1'b0, cval_q} + 17'h00001;
	// Per-leg rescale, duty and time; the zero vectors fill the rest
	svp_ph_t   scl_w [3];
	svp_time_t tim_w [3];
	logic [2:0] hi_d;
	logic [2:0] lo_d;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_leg
			wire signed [53:0] sp = ph_q[g] * $signed({1'b0, k_q});
			wire signed [51:0] fp = ph_q[g] * `SVP_THIRD;
			wire signed [17:0] du = `SVP_MID + $signed(fp[42:25]);
			wire [15:0]        dc = du[17] ? 16'h0 :
				(du[16] ? 16'hffff : du[15:0]);
			wire [32:0]        tp = dc * cp1;
			wire [16:0]        th = (t_act_q[g] > {1'b0, dt_act_q}) ?
				t_act_q[g] - {1'b0, dt_act_q} : 17'h0;
			assign scl_w[g] = $signed(sp[51:16]);
			assign tim_w[g] = tp[32:16];
			// High side starts late and ends early by the deadtime
			assign hi_d[g] = run_q & ({1'b0, cnt_q} < th);
			assign lo_d[g] = run_q & ({1'b0, cnt_q} >= t_act_q[g]);
		end
	endgenerate
	// Calculation sequencer; a trigger edge while busy is ignored
	wire start = vector_calc_trigger & ~trig_q & ~busy;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q      <= S_IDLE;
			trig_q    <= 1'b0;
			cmd_q     <= '0;
			tl_calc_q <= 1'b0;
			cyc_q     <= 6'h0;
		end else if (ce) begin
			trig_q <= vector_calc_trigger;
			cyc_q  <= busy ? cyc_q + 6'h01 : 6'h0;
			case (st_q)
				S_IDLE: if (start) begin
					cmd_q     <= cmd;
					tl_calc_q <= twoleg_q;
					cyc_q     <= 6'h01;
					st_q      <= S_MUL;
				end
				S_MUL: st_q <= S_PHS;
				S_PHS: st_q <= S_SPR;
				S_SPR: st_q <= ovm_w ? S_DIV : S_SCL;
				S_DIV: if (bit_q == `SVP_DIV_ITER - 5'h01)
					st_q <= S_SCL;
				S_SCL: st_q <= S_CTR;
				S_CTR: st_q <= S_DUT;
				// Pad the short path so its latency is fixed at the typical count
				S_DUT: if (cyc_q >= `SVP_CALC_TYP - 6'h01)
					st_q <= S_IDLE;
				default: st_q <= S_IDLE;
			endcase
		end
	end
	// Datapath registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pa_q  <= '0;
			pb_q  <= '0;
			ph_q  <= '{default: '0};
			ovm_q <= 1'b0;
			rem_q <= 37'h0;
			dv_q  <= 36'h0;
			k_q   <= `SVP_UNITY;
			bit_q <= 5'h0;
			sec_q <= 3'h0;
		end else if (ce) begin
			case (st_q)
				S_MUL: begin
					pa_q <= 36'(cmd_q.alpha * $signed({1'b0, scl_q}));
					pb_q <= 36'(cmd_q.beta * $signed({1'b0, scl_q}));
				end
				S_PHS: begin
					ph_q[0] <= pa_q;
					ph_q[1] <= sq - hlf;
					ph_q[2] <= -sq - hlf;
				end
				S_SPR: begin
					ovm_q <= ovm_w;
					sec_q <= svp_sector(ord);
					rem_q <= {1'b0, `SVP_LIM};
					dv_q  <= spr;
					bit_q <= 5'h0;
					k_q   <= ovm_w ? 17'h0 : `SVP_UNITY;
				end
				// Restoring divide: k = limit / spread in 1.16
				S_DIV: begin
					rem_q <= q_bit ? rem_s - {1'b0, dv_q} : rem_s;
					k_q   <= {k_q[15:0], q_bit};
					bit_q <= bit_q + 5'h01;
				end
				// Uniform scale keeps the vector angle
				S_SCL: ph_q <= scl_w;
				S_CTR: for (int i = 0; i < 3; i++)
					ph_q[i] <= ph_q[i] - off;
				default: ;
			endcase
		end
	end
	// Shadow copy written at the end of the calculation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_sh_q  <= '{default: '0};
			tl_sh_q <= 1'b0;
		end else if (ce && st_q == S_DUT &&
			cyc_q >= `SVP_CALC_TYP - 6'h01) begin
			t_sh_q  <= tim_w;
			tl_sh_q <= tl_calc_q;
		end
	end
	// Carrier: up then down, each end held one extra clock
	wire at_peak = up_q & (cnt_q >= cval_q);
	wire at_zero = ~up_q & (cnt_q == 16'h0);
	wire ev      = at_zero | (at_peak & ~align_q);
	wire xfer    = ~run_q | ev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0;
			up_q  <= 1'b1;
		end else if (ce) begin
			if (!run_q) begin
				cnt_q <= 16'h0;
				up_q  <= 1'b1;
			end else if (at_peak)
				up_q <= 1'b0;
			else if (at_zero)
				up_q <= 1'b1;
			else if (up_q)
				cnt_q <= cnt_q + 16'h0001;
			else
				cnt_q <= cnt_q - 16'h0001;
		end
	end
	// Boundary transfer; asymmetric mode also updates mid-cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t_act_q  <= '{default: '0};
			dt_act_q <= `SVP_RST_DEAD;
			tl_act_q <= 1'b0;
			bnd_n_q  <= 1'b1;
		end else if (ce) begin
			bnd_n_q <= ~(run_q & ev);
			if (xfer) begin
				t_act_q  <= t_sh_q;
				dt_act_q <= dt_q;
				tl_act_q <= tl_sh_q;
			end
		end
	end
	// Registered gate drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_q <= 3'h0;
			lo_q <= 3'h0;
		end else if (ce) begin
			hi_q <= hi_d;
			lo_q <= lo_d;
		end
	end
	assign cycle_boundary_n = bnd_n_q;
	assign leg_u_timing     = t_act_q[0];
	assign leg_v_timing     = t_act_q[1];
	assign leg_w_timing     = t_act_q[2];
	assign gates = {hi_q[0], lo_q[0], hi_q[1], lo_q[1], hi_q[2], lo_q[2]};

	// Checks on the design's own outputs and internal state
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn || !ce);
	property p_gate_excl;
		(hi_q & lo_q) == 3'h0;
	endproperty
	a_gate_excl: assert property (p_gate_excl) else $error("leg shoot");
	property p_lat_max;
		start |-> ##[1:35] (st_q == S_IDLE);
	endproperty
	a_lat_max: assert property (p_lat_max) else $error("calc slow");
	property p_lat_typ;
		($fell(busy) && !ovm_q) |-> ($past(cyc_q) == 6'h0a);
	endproperty
	a_lat_typ: assert property (p_lat_typ) else $error("calc late");
	property p_xfer;
		(run_q && ev) |=> (t_act_q[0] == $past(t_sh_q[0])) && !bnd_n_q;
	endproperty
	a_xfer: assert property (p_xfer) else $error("no transfer");
	// Bound by the count in force when the step was taken, so a rewrite
	// of the carrier count in that same cycle does not fire it
	property p_carrier;
		(run_q && $stable(cval_q) && cnt_q <= cval_q) |=>
			cnt_q <= $past(cval_q);
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier");
	property p_supp;
		(run_q && t_act_q[0] <= {1'b0, dt_act_q}) |=> !hi_q[0];
	endproperty
	a_supp: assert property (p_supp) else $error("short pulse");
	property p_twoleg;
		(run_q && tl_act_q) |-> (t_act_q[0] == 17'h0 ||
			t_act_q[1] == 17'h0 || t_act_q[2] == 17'h0);
	endproperty
	a_twoleg: assert property (p_twoleg) else $error("no clamp");
	property p_sym;
		(run_q && align_q && at_peak) |=> bnd_n_q;
	endproperty
	a_sym: assert property (p_sym) else $error("sym update");

endmodule : svp_space_vector_pwm

/* tb/svp_ctl_model.sv */
// Control loop model that issues modulation commands
`timescale 1ns/1ps

module svp_ctl_model (
	// Clock
	input  wire logic        pclk,
	// Cycle marker from the generator
	input  wire logic        cycle_boundary_n,
	// Command towards the generator
	output svp_pkg::svp_cmd_t cmd,
	output logic             vector_calc_trigger
);
	import svp_pkg::*;

	// Quiet at time zero
	initial begin
		cmd = '0;
		vector_calc_trigger = 1'b0;
	end

	// Fire just after a boundary so a whole half cycle of margin remains
	// Lag models a slow controller and must stay well under that margin
	task automatic send(input logic signed [15:0] a,
		input logic signed [15:0] b, input int lag);
		do @(posedge pclk); while (cycle_boundary_n !== 1'b0);
		repeat (lag) @(posedge pclk);
		cmd <= '{alpha: a, beta: b};
		vector_calc_trigger <= 1'b1;
		@(posedge pclk);
		vector_calc_trigger <= 1'b0;
		// Scrambled once taken, so a late capture shows up
		cmd <= ~{a, b};
	endtask : send
endmodule : svp_ctl_model

/* tb/space_vector_pwm_generator_test.sv */
// Self-checking bench of the space vector PWM generator
`timescale 1ns/1ps
`include "svp_cfg.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	n_fail++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
	end end

module space_vector_pwm_generator_test;
	import svp_pkg::*;
	// 2.5 MHz PWM at a 250 MHz clock
	localparam int CN = 250_000_000 / (2 * 2_500_000) - 1;
	localparam int DT = 4;
	localparam logic signed [15:0] TA [6] = '{17320, 0, -17320,
		-17320, 0, 17320};
	localparam logic signed [15:0] TB [6] = '{10000, 20000, 10000,
		-10000, -20000, -10000};
	localparam int MX [6] = '{0, 1, 1, 2, 2, 0};
	localparam int MN [6] = '{2, 2, 0, 0, 1, 1};
	logic        pclk, presetn, ce, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, trig, cbn, hp;
	svp_cmd_t    cmd;
	svp_time_t   lg [3];
	svp_time_t   md;
	svp_gate_t   gates;
	logic [32:0] qe [$], qm [$];
	logic [32:0] e, re, rm;
	logic [50:0] old;
	int          n_fail, samples_checked, n, gap, hits;

	svp_space_vector_pwm i_dut (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cmd(cmd),
		.vector_calc_trigger(trig), .cycle_boundary_n(cbn),
		.leg_u_timing(lg[0]), .leg_v_timing(lg[1]),
		.leg_w_timing(lg[2]), .gates(gates));

	svp_ctl_model i_ctl (.pclk(pclk), .cycle_boundary_n(cbn),
		.cmd(cmd), .vector_calc_trigger(trig));

	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task automatic tally_and_finish;
		if (n_fail == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	// One APB transfer; a read leaves its expectation in the queue
	task automatic apb(input bit w, input logic [7:0] a,
		input logic [31:0] d, input logic [32:0] x, input logic [32:0] k);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		if (!w) begin
			qe.push_back(x);
			qm.push_back(k);
		end
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic wb;
		do @(posedge pclk); while (cbn !== 1'b0);
	endtask : wb

	// Cycles between two boundary pulses, after the mode has settled
	task automatic span(input int x);
		wb;
		wb;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cbn !== 1'b0);
		`CHK(n, x)
	endtask : span

	// Read checker takes the oldest note at each completed read
	always @(posedge pclk)
		if (psel && penable && pready && !pwrite) begin
			re = qe.pop_front();
			rm = qm.pop_front();
			`CHK({pslverr, prdata} & rm, re)
		end

	// Gate watch: no overlap, and the gap from high off to low on
	always @(posedge pclk) begin
		`CHK(gates & (gates >> 1) & 6'h15, 6'h00)
		if (hp && !gates.gate_u_high)
			gap <= 1;
		else if (gap != 0 && gates.gate_u_low) begin
			`CHK(gap, DT)
			hits++;
			gap <= 0;
		end else if (gap != 0)
			gap <= gap + 1;
		hp <= gates.gate_u_high;
	end

	// Deadlock guard, far beyond the fewer than two thousand cycles of the tests
	initial begin
		#100000;
		n_fail++;
		tally_and_finish;
	end

	// Main sequence
	initial begin
		void'($urandom(32'h4b7d));
		{ce, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		ce = 1'b1;
		{n_fail, samples_checked, gap, hits} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `SVP_OFF_CTRL, 0, 33'h0, '1);
		apb(0, `SVP_OFF_CARR, 0, 33'h1387, '1);
		apb(0, `SVP_OFF_SCALE, 0, 33'h0, '1);
		apb(0, `SVP_OFF_DEAD, 0, 33'h64, '1);
		apb(0, 8'h14, 0, 33'h100000000, '1);
		e = 33'($urandom & 32'h7fff);
		apb(1, `SVP_OFF_SCALE, e[31:0], 0, 0);
		// Clock enable drops in the access phase: the read must wait
		fork
			apb(0, `SVP_OFF_SCALE, 0, e, '1);
			begin
				repeat (2) @(posedge pclk);
				ce <= 1'b0;
				repeat (3) @(posedge pclk);
				ce <= 1'b1;
			end
		join
		apb(1, `SVP_OFF_SCALE, 1000, 0, 0);
		apb(1, `SVP_OFF_CARR, CN, 0, 0);
		apb(1, `SVP_OFF_DEAD, DT, 0, 0);
		apb(1, `SVP_OFF_CTRL, 32'h5, 0, 0);
		span(2 * (CN + 1));
		apb(1, `SVP_OFF_CTRL, 32'h4, 0, 0);
		span(CN + 1);
		// One command in the middle of each sector
		for (int i = 0; i < 6; i++) begin
			old = {lg[0], lg[1], lg[2]};
			i_ctl.send(TA[i], TB[i], 0);
			repeat (12) @(posedge pclk);
			apb(0, `SVP_OFF_STAT, 0, 33'(i + 1), 33'h67);
			`CHK({lg[0], lg[1], lg[2]}, old)
			wb;
			repeat (2) @(posedge pclk);
			md = lg[3 - MX[i] - MN[i]];
			`CHK({lg[MX[i]] > md, md > lg[MN[i]]}, 2'b11)
		end
		// Two-leg pattern with a slow controller
		apb(1, `SVP_OFF_CTRL, 32'h6, 0, 0);
		i_ctl.send(TA[0], TB[0], $urandom % 8);
		wb;
		repeat (2) @(posedge pclk);
		`CHK(lg[2], 17'h0)
		n = 0;
		repeat (2 * (CN + 1)) begin
			@(posedge pclk);
			// Unknown gate levels count as pulses
			if (gates.gate_w_high !== 1'b0)
				n++;
		end
		`CHK(n, 0)
		// Over-modulation keeps the sector and stays inside the hexagon
		apb(1, `SVP_OFF_CTRL, 32'h4, 0, 0);
		apb(1, `SVP_OFF_SCALE, 32767, 0, 0);
		i_ctl.send(TA[0], TB[0], 0);
		apb(0, `SVP_OFF_STAT, 0, 33'h40, 33'h40);
		repeat (32) @(posedge pclk);
		apb(0, `SVP_OFF_STAT, 0, 33'h21, 33'h67);
		wb;
		repeat (2) @(posedge pclk);
		`CHK({lg[0] > lg[1], lg[1] > lg[2], lg[0] <= CN + 1}, 3'b111)
		`CHK(hits != 0, 1'b1)
		tally_and_finish;
	end
endmodule : space_vector_pwm_generator_test
